// file: pkg/dep_defs.svh
`ifndef DEP_DEFS_SVH
`define DEP_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DEP_ROUTING_OFS 12'h000
`define DEP_STATUS_OFS 12'h004
`define DEP_ROUTING_RST 32'h00000000
`define DEP_ROUTING_WMASK 32'h0111ffff

// ****************************************************************
// Routing register fields
// ****************************************************************
`define DEP_IN0_ALT_LSB 0
`define DEP_IN1_ALT_LSB 4
`define DEP_OUT0_ALT_LSB 8
`define DEP_OUT1_ALT_LSB 12
`define DEP_IN0_ALT_PIN_EN 16
`define DEP_IN1_ALT_PIN_EN 20
`define DEP_OUT0_ALT_PIN_EN 24

// ****************************************************************
// Status register fields
// ****************************************************************
`define DEP_ST_IN_LSB 0
`define DEP_ST_OE_LSB 16
`define DEP_ST_IN0_BAD 30
`define DEP_ST_IN1_BAD 31

// ****************************************************************
// Sizes and timing
// ****************************************************************
`define DEP_NUM_PINS 10
`define DEP_NUM_PERIPH 17
`define DEP_CLK_MHZ 40
`define DEP_IRC_MHZ 16
// Stretch length in internal oscillator periods
`define DEP_STRETCH_IRC 2
`define DEP_STRETCH_CYC \
   ((`DEP_STRETCH_IRC * `DEP_CLK_MHZ + `DEP_IRC_MHZ - 1) / `DEP_IRC_MHZ)

`endif

// file: pkg/dep_pkg.sv
package dep_pkg;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dep_apb_req_s;

   typedef struct packed
   {
      logic prdata_unused;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dep_apb_rsp_s;

   // Parties that raise event_in
   typedef struct packed
   {
      logic jtag_master_unit;
      logic debug_pattern_unit;
   } dep_in_src_s;

   // Parties that raise event_out
   typedef struct packed
   {
      logic cores;
      logic security_module;
      logic timer_module;
      logic trace_controller;
      logic debug_pattern_unit;
   } dep_out_src_s;

   // Receivers of event_in 0
   typedef struct packed
   {
      logic cores;
      logic security_module;
      logic timer_module;
      logic trace_controller;
   } dep_in0_dest_s;

endpackage : dep_pkg

// file: hw/dep_apb_regs.sv
`timescale 1ns/1ps
`include "dep_defs.svh"

module dep_apb_regs
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire dep_pkg::dep_apb_req_s i_apb,
   input wire logic [31:0] i_status,
   output dep_pkg::dep_apb_rsp_s o_apb,
   output logic [31:0] o_routing
);

   logic [31:0] routing_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic hit_routing;
   logic hit_status;
   logic access;

   assign hit_routing = (i_apb.paddr == `DEP_ROUTING_OFS);
   assign hit_status = (i_apb.paddr == `DEP_STATUS_OFS);
   assign access = i_apb.psel && i_apb.penable;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         routing_r <= `DEP_ROUTING_RST;
      else if (access && i_apb.pwrite && hit_routing)
         routing_r <= i_apb.pwdata & `DEP_ROUTING_WMASK;
   end

   // Read data and error settle in the setup cycle, so zero wait states
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else if (i_apb.psel && !i_apb.penable)
      begin
         pslverr_r <= !(hit_routing || (hit_status && !i_apb.pwrite));
         if (i_apb.pwrite)
            prdata_r <= 32'h00000000;
         else if (hit_routing)
            prdata_r <= routing_r;
         else if (hit_status)
            prdata_r <= i_status;
         else
            prdata_r <= 32'h00000000;
      end
   end

   // One driver for the whole response word
   assign o_apb = '{prdata_unused: 1'b0,
                    pready: 1'b1,
                    pslverr: pslverr_r && access,
                    prdata: prdata_r};
   assign o_routing = routing_r;

endmodule : dep_apb_regs

// file: hw/dep_stretch.sv
`timescale 1ns/1ps
`include "dep_defs.svh"

module dep_stretch
#(
   parameter int STRETCH = `DEP_STRETCH_CYC
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_evt,
   output logic o_evt
);

   localparam int CW = $clog2(STRETCH + 1);
   localparam logic [CW-1:0] LOAD = CW'(STRETCH);

   logic evt_d_r;
   logic [CW-1:0] cnt_r;
   logic out_r;

   // Edge detect on a synchronous input
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         evt_d_r <= 1'b0;
      else
         evt_d_r <= i_evt;
   end

   // Hold counter in units of the fast clock, covering the oscillator periods
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         cnt_r <= '0;
      else if (i_evt && !evt_d_r)
         cnt_r <= LOAD;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         out_r <= 1'b0;
      else
         out_r <= i_evt || (cnt_r != '0);
   end

   assign o_evt = out_r;

endmodule : dep_stretch

// file: hw/dep_event_routing.sv
// Behaviour
// - A pin enabled for both an event input and an event output is given to the input.
// - An event input whose select bits enable more than one pin enables no pin at all.
// - Event input 0 comes from one of five pins chosen by bits 0 to 3 and bit 16.
// - Event input 1 comes from one of five pins chosen by bits 4 to 7 and bit 20.
// - Event output 0 drives every pin enabled by bits 8 to 11 and bit 24.
// - Event output 1 drives every pin enabled by bits 12 to 15.
// - Event outputs to the jtag master unit are stretched over oscillator periods.
// - Event input 0 comes from the jtag master or pattern unit and reaches four receivers.
// - One system debug flag is fanned out to a fixed set of peripherals.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dep_defs.svh"

module dep_event_routing
#(
   parameter int NUM_PINS = `DEP_NUM_PINS,
   parameter int NUM_PERIPH = `DEP_NUM_PERIPH,
   parameter int STRETCH = `DEP_STRETCH_CYC
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire dep_pkg::dep_apb_req_s i_apb,
   output dep_pkg::dep_apb_rsp_s o_apb,
   input wire logic [NUM_PINS-1:0] i_pin_in,
   output logic [NUM_PINS-1:0] o_pin_out,
   output logic [NUM_PINS-1:0] o_pin_oe,
   input wire dep_pkg::dep_in_src_s i_in0_src,
   input wire dep_pkg::dep_in_src_s i_in1_src,
   input wire dep_pkg::dep_out_src_s i_out0_src,
   input wire dep_pkg::dep_out_src_s i_out1_src,
   input wire logic i_sys_debug,
   output dep_pkg::dep_in0_dest_s o_in0_dest,
   output logic o_in1_pattern_unit,
   output logic [1:0] o_event_out_jtag,
   output logic [1:0] o_event_out_pattern_unit,
   output logic [NUM_PERIPH-1:0] o_periph_debug
);

   // ****************************************************************
   // Pin order: 0 PF14, 1 PF15, 2 PM4, 3 PM5, 4 PA8,
   //            5 PH11, 6 PK14, 7 PM6, 8 PM7, 9 PA9
   // ****************************************************************

   logic [31:0] routing;
   logic [31:0] status;
   logic [NUM_PINS-1:0] in0_sel;
   logic [NUM_PINS-1:0] in1_sel;
   logic [NUM_PINS-1:0] out0_sel;
   logic [NUM_PINS-1:0] out1_sel;
   logic in0_bad;
   logic in1_bad;
   logic [NUM_PINS-1:0] in_take;
   logic [NUM_PINS-1:0] oe_nxt;
   logic [NUM_PINS-1:0] out_nxt;
   logic [NUM_PINS-1:0] pin_active;
   logic in0_pin;
   logic in1_pin;
   logic event_in0;
   logic event_in1;
   logic event_out0;
   logic event_out1;
   logic [NUM_PINS-1:0] pin_out_r;
   logic [NUM_PINS-1:0] pin_oe_r;
   logic [3:0] in0_dest_r;
   logic in1_dest_r;
   logic [1:0] out_pu_r;
   logic [NUM_PERIPH-1:0] debug_r;

   // ****************************************************************
   // Register file
   // ****************************************************************
   dep_apb_regs u_regs
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_apb(i_apb),
      .i_status(status),
      .o_apb(o_apb),
      .o_routing(routing)
   );

   // ****************************************************************
   // Select decode
   // ****************************************************************
   // input 0 pins
   assign in0_sel = {5'b00000, routing[`DEP_IN0_ALT_PIN_EN],
                     routing[`DEP_IN0_ALT_LSB +: 4]};
   assign in1_sel = {routing[`DEP_IN1_ALT_PIN_EN],
                     routing[`DEP_IN1_ALT_LSB +: 4], 5'b00000};
   assign out0_sel = {5'b00000, routing[`DEP_OUT0_ALT_PIN_EN],
                      routing[`DEP_OUT0_ALT_LSB +: 4]};
   // output 1 pins, no fifth pin on PM7
   assign out1_sel = {routing[`DEP_OUT1_ALT_LSB + 3], 1'b0,
                      routing[`DEP_OUT1_ALT_LSB +: 3], 5'b00000};

   // more than one pin disables every pin of the input
   assign in0_bad = !$onehot0(in0_sel);
   assign in1_bad = !$onehot0(in1_sel);
   assign in_take = (in0_bad ? '0 : in0_sel) | (in1_bad ? '0 : in1_sel);

   // Pins are active low on the board
   assign pin_active = ~i_pin_in;
   assign in0_pin = |(pin_active & (in0_bad ? '0 : in0_sel));
   assign in1_pin = |(pin_active & (in1_bad ? '0 : in1_sel));

   assign event_in0 = in0_pin || i_in0_src.jtag_master_unit || i_in0_src.debug_pattern_unit;
   assign event_in1 = in1_pin || i_in1_src.jtag_master_unit || i_in1_src.debug_pattern_unit;

   assign event_out0 = i_out0_src.cores || i_out0_src.security_module ||
                       i_out0_src.timer_module || i_out0_src.trace_controller ||
                       i_out0_src.debug_pattern_unit;
   assign event_out1 = i_out1_src.cores || i_out1_src.security_module ||
                       i_out1_src.timer_module || i_out1_src.trace_controller ||
                       i_out1_src.debug_pattern_unit;

   assign oe_nxt = (out0_sel | out1_sel) & ~in_take;
   // Each output pulls its own enabled pins low; the two pin sets never overlap
   assign out_nxt = ~((out0_sel & {NUM_PINS{event_out0}}) |
                      (out1_sel & {NUM_PINS{event_out1}}));

   // Status fields hold ten pins; a wider pin set is cut to fit the word
   assign status = {in1_bad, in0_bad, 4'h0, 10'(oe_nxt), 6'h00, 10'(in_take)};

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   // drive selected pins
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pin_oe_r <= '0;
         pin_out_r <= '1;
      end
      else
      begin
         pin_oe_r <= oe_nxt;
         pin_out_r <= out_nxt;
      end
   end

   assign o_pin_oe = pin_oe_r;
   assign o_pin_out = pin_out_r;

   // ****************************************************************
   // Event input delivery
   // ****************************************************************
   // deliver input 0 to its receivers
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         in0_dest_r <= 4'h0;
         in1_dest_r <= 1'b0;
      end
      else
      begin
         in0_dest_r <= {4{event_in0}};
         in1_dest_r <= event_in1;
      end
   end

   assign o_in0_dest = dep_pkg::dep_in0_dest_s'(in0_dest_r);
   assign o_in1_pattern_unit = in1_dest_r;

   // ****************************************************************
   // Event output delivery
   // ****************************************************************
   // The pattern unit sits on the fast clock and needs no stretch
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         out_pu_r <= 2'b00;
      else
         out_pu_r <= {event_out1, event_out0};
   end

   assign o_event_out_pattern_unit = out_pu_r;

   // stretch toward the jtag master unit
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_stretch
         dep_stretch #(.STRETCH(STRETCH)) u_stretch
         (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_evt(gi == 0 ? event_out0 : event_out1),
            .o_evt(o_event_out_jtag[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // System debug fan-out
   // ****************************************************************
   // one flag to every peripheral
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         debug_r <= '0;
      else
         debug_r <= {NUM_PERIPH{i_sys_debug}};
   end

   assign o_periph_debug = debug_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   property p_in_wins;
      (|((out0_sel | out1_sel) & in_take)) |=> !(|($past(in_take) & o_pin_oe));
   endproperty
   a_in_wins: assert property (p_in_wins) else $error("shared pin driven by output");

   property p_in0_bad;
      (in0_bad && !i_in0_src.jtag_master_unit && !i_in0_src.debug_pattern_unit)
         |=> !o_in0_dest.cores;
   endproperty
   a_in0_bad: assert property (p_in0_bad) else $error("invalid input 0 select passed");

   property p_in0_pin;
      ($onehot(in0_sel) && |(in0_sel & ~i_pin_in)) |=> o_in0_dest.timer_module;
   endproperty
   a_in0_pin: assert property (p_in0_pin) else $error("input 0 pin not delivered");

   property p_in1_pin;
      ($onehot(in1_sel) && |(in1_sel & ~i_pin_in)) |=> o_in1_pattern_unit;
   endproperty
   a_in1_pin: assert property (p_in1_pin) else $error("input 1 pin not delivered");

   property p_out0_drive;
      (event_out0 && |(out0_sel & ~in_take))
         |=> |(o_pin_oe & ~o_pin_out & $past(out0_sel));
   endproperty
   a_out0_drive: assert property (p_out0_drive) else $error("output 0 not driven");

   property p_out1_drive;
      (event_out1 && |(out1_sel & ~in_take))
         |=> |(o_pin_oe & ~o_pin_out & $past(out1_sel));
   endproperty
   a_out1_drive: assert property (p_out1_drive) else $error("output 1 not driven");

   property p_stretch;
      $rose(event_out0) |=> o_event_out_jtag[0] [*5];
   endproperty
   a_stretch: assert property (p_stretch) else $error("jtag event not stretched");

   property p_in0_fan;
      i_in0_src.jtag_master_unit |=> (o_in0_dest == 4'hf);
   endproperty
   a_in0_fan: assert property (p_in0_fan) else $error("input 0 not fanned out");

   property p_debug_fan;
      i_sys_debug |=> (&o_periph_debug) ##1 ($past(i_sys_debug) == o_periph_debug[0]);
   endproperty
   a_debug_fan: assert property (p_debug_fan) else $error("debug flag not fanned out");

   property p_reset_clear;
      $fell(i_sys_rst) |-> (routing == 32'h00000000) && (o_pin_oe == '0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("routing not clear at reset");

   c_conflict: cover property (|((out0_sel | out1_sel) & in_take));
   c_in_bad: cover property (in0_bad ##1 !in0_bad);
   c_out_pin: cover property (event_out0 && |o_pin_oe);
   c_stretch: cover property ($fell(event_out0) ##1 o_event_out_jtag[0]);

endmodule : dep_event_routing

// file: tb/dep_far_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Far side: port pins with pull-ups and the jtag master unit
// ****************************************************************
module dep_far_model
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [9:0] i_drive_low,
   input wire logic [9:0] i_pin_out,
   input wire logic [9:0] i_pin_oe,
   input wire logic [1:0] i_event_out_jtag,
   output logic [9:0] o_pin_level,
   output logic [7:0] o_jtag_seen
);
   logic last_r;

   // Released pins float to the pull-up level; outside parties only pull low
   always_comb
   begin
      for (int i = 0; i < 10; i++)
      begin
         o_pin_level[i] = i_pin_oe[i] ? i_pin_out[i] : ~i_drive_low[i];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         last_r <= 1'b0;
         o_jtag_seen <= 8'h00;
      end
      else
      begin
         last_r <= i_event_out_jtag[0];
         if (i_event_out_jtag[0] && !last_r)
            o_jtag_seen <= o_jtag_seen + 8'h01;
      end
   end
endmodule : dep_far_model

// file: tb/debug_event_pin_routing_test.sv
`timescale 1ns/1ps
`include "dep_defs.svh"

module debug_event_pin_routing_test;
   logic i_clk;
   logic i_sys_rst;
   dep_pkg::dep_apb_req_s apb;
   dep_pkg::dep_apb_rsp_s rsp;
   logic [9:0] pin_in, pin_out, pin_oe, drive_low, m, mn;
   dep_pkg::dep_in_src_s in0_src, in1_src;
   dep_pkg::dep_out_src_s out0_src, out1_src;
   dep_pkg::dep_in0_dest_s in0_dest;
   logic sys_debug, in1_pu, err;
   logic [1:0] evo_jtag, evo_pu;
   logic [16:0] periph;
   logic [7:0] jtag_seen, seen0;
   logic [31:0] q;
   int mismatches, checked, cycles, k, f;
   // Select bit and pin per entry; entry/5 gives in0, in1, out0, out1
   int tbit [19] = '{0, 1, 2, 3, 16, 4, 5, 6, 7, 20, 8, 9, 10, 11, 24, 12, 13, 14, 15};
   int tpin [19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 1, 2, 3, 4, 5, 6, 7, 9};

   dep_event_routing uut
   (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_apb(apb), .o_apb(rsp),
      .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
      .i_in0_src(in0_src), .i_in1_src(in1_src), .i_out0_src(out0_src),
      .i_out1_src(out1_src), .i_sys_debug(sys_debug), .o_in0_dest(in0_dest),
      .o_in1_pattern_unit(in1_pu), .o_event_out_jtag(evo_jtag),
      .o_event_out_pattern_unit(evo_pu), .o_periph_debug(periph)
   );

   dep_far_model far
   (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_drive_low(drive_low),
      .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_event_out_jtag(evo_jtag),
      .o_pin_level(pin_in), .o_jtag_seen(jtag_seen)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task test_done;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         mismatches++;
         test_done();
      end
   end

   task cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One APB transfer; the request stands until pready is seen high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge i_clk);
      apb.penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
      end
      while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      err = rsp.pslverr;
      apb <= '0;
   endtask : xfer

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      i_sys_rst = 1'b1;
      apb = '0;
      drive_low = 10'h000;
      in0_src = '0;
      in1_src = '0;
      out0_src = '0;
      out1_src = '0;
      sys_debug = 1'b0;
      cyc(12);
      i_sys_rst <= 1'b0;
      xfer(1'b0, `DEP_ROUTING_OFS, 32'h0);
      chk(q, `DEP_ROUTING_RST, "routing after reset");
      chk(pin_oe, 32'h0, "no pin driven after reset");
      chk(pin_out, 32'h3ff, "pin drive idle high");
      xfer(1'b1, `DEP_ROUTING_OFS, 32'hffffffff);
      xfer(1'b0, `DEP_ROUTING_OFS, 32'h0);
      chk(q, `DEP_ROUTING_WMASK, "writable routing bits");
      xfer(1'b0, 12'h008, 32'h0);
      chk(err, 32'h1, "unmapped read refused");
      xfer(1'b1, `DEP_STATUS_OFS, 32'hffffffff);
      chk(err, 32'h1, "status write refused");
      $display("test registers done");

      // Each select bit alone, so no input and output share a pin
      for (k = 0; k < 19; k++)
      begin
         f = k / 5;
         m = 10'h001 << tpin[k];
         mn = ~m;
         xfer(1'b1, `DEP_ROUTING_OFS, 32'h1 << tbit[k]);
         cyc(2);
         if (f < 2)
         begin
            drive_low <= m;
            cyc(3);
            chk(f == 0 ? 32'(in0_dest) : 32'(in1_pu), f == 0 ? 32'hf : 32'h1, "in on pin");
            drive_low <= mn;
            cyc(3);
            chk(f == 0 ? 32'(in0_dest) : 32'(in1_pu), 32'h0, "other pins ignored");
            drive_low <= 10'h000;
         end
         else
         begin
            chk(pin_oe, m, "output enable on pin");
            chk(pin_in, 32'h3ff, "idle output level");
            if (f == 2)
               out0_src.cores <= 1'b1;
            else
               out1_src.trace_controller <= 1'b1;
            cyc(3);
            chk(pin_in, mn, "output event on pin");
            out0_src <= '0;
            out1_src <= '0;
            cyc(12);
         end
      end
      $display("test pin selects done");

      // Input and output both on pin 0: the input must win
      xfer(1'b1, `DEP_ROUTING_OFS, 32'h00000101);
      out0_src.cores <= 1'b1;
      cyc(3);
      chk(pin_oe, 32'h0, "shared pin not driven");
      chk(in0_dest, 32'h0, "no event while pin high");
      xfer(1'b0, `DEP_STATUS_OFS, 32'h0);
      chk(q, 32'h00000001, "status shows pin taken by input");
      drive_low <= 10'h001;
      cyc(3);
      chk(in0_dest, 32'hf, "shared pin feeds input");
      out0_src <= '0;
      drive_low <= 10'h3ff;
      xfer(1'b1, `DEP_ROUTING_OFS, 32'h00110033);
      cyc(3);
      chk(in0_dest, 32'h0, "in0 multi select off");
      chk(in1_pu, 32'h0, "in1 multi select off");
      xfer(1'b0, `DEP_STATUS_OFS, 32'h0);
      chk(q, 32'hc0000000, "both inputs flagged invalid");
      xfer(1'b1, `DEP_ROUTING_OFS, 32'h00000001);
      cyc(3);
      chk(in0_dest, 32'hf, "single select recovers");
      drive_low <= 10'h000;
      xfer(1'b1, `DEP_ROUTING_OFS, 32'h0);
      $display("test conflicts done");

      // Internal sources of both inputs
      for (k = 0; k < 2; k++)
      begin
         in0_src <= 2'b10 >> k;
         in1_src <= 2'b10 >> k;
         cyc(3);
         chk(in0_dest, 32'hf, "in0 from internal source");
         chk(in1_pu, 32'h1, "in1 from internal source");
         in0_src <= '0;
         in1_src <= '0;
         cyc(3);
         chk(in0_dest, 32'h0, "in0 released");
      end
      $display("test internal sources done");

      // One-cycle output event must be stretched toward the jtag master
      seen0 = jtag_seen;
      out0_src.security_module <= 1'b1;
      cyc(1);
      out0_src <= '0;
      cyc(1);
      chk(evo_pu, 32'h1, "out0 to pattern unit");
      cyc(1);
      for (k = 0; k < 4; k++)
      begin
         cyc(1);
         chk(evo_jtag[0], 32'h1, "stretched event high");
      end
      out1_src.debug_pattern_unit <= 1'b1;
      cyc(3);
      chk(evo_pu, 32'h2, "out1 to pattern unit");
      out1_src <= '0;
      cyc(20);
      chk(evo_jtag, 32'h0, "stretch ends");
      chk(jtag_seen, seen0 + 8'h01, "one event seen");
      $display("test stretch done");

      sys_debug <= 1'b1;
      cyc(3);
      chk(periph, 32'h1ffff, "debug flag fanned out");
      sys_debug <= 1'b0;
      cyc(3);
      chk(periph, 32'h0, "debug flag cleared");
      $display("test debug flag done");
      test_done();
   end
endmodule : debug_event_pin_routing_test
